// File: bca_bus_cycle_ack_control.sv
// Processor bus-cycle control: acknowledge, bus error, triggers, interrupts, latching
`timescale 1ns/1ps
// How it works
// - I/O cycles get wait states before acknowledge
// - Count processor clocks, hold acknowledge until reached
// - Jumper selects wait count, fitted as four
// - ROM and RAM acknowledged at once
// - Acknowledge only pulls shared line active
// - Trigger port reads eight trigger lines
// - Trigger from backplane lines or front input
// - Separate upper and lower byte write strobes
// - Analog interrupts pass through removable jumpers
// - Seven autovectored levels presented to processor
// - Three user levels, higher number wins
// - Processor clock is backplane clock halved
// - Bus error after 16 us unacknowledged
// - Backplane address latched inbound, passed outbound
// - Processor data word drives upper address
// - Transceiver direction and enable from bus activity
// - Stretch address-space access pulses for indicators
// - Deselect battery RAM bank on power loss
module bca_bus_cycle_ack_control import bca_pkg::*; #(
    parameter int LED_STRETCH_CYCLES = LED_STRETCH_DEF
) (
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    reset,
    // Backplane clock in, processor clock out
    input  wire logic                    bp_clk_16m,
    output logic                         cpu_clk,
    // Processor cycle
    input  wire logic                    cpu_as_n,
    input  wire logic                    cpu_rw,
    input  wire logic                    cpu_uds_n,
    input  wire logic                    cpu_lds_n,
    input  wire logic                    io_sel,
    input  wire logic                    mem_sel,
    input  wire logic                    trigger_port_select,
    input  wire logic                    a32_hi_sel,
    input  wire logic [WAIT_W-1:0]       wait_count_jumper,
    input  wire logic [DATA_W-1:0]       cpu_data_i,
    output logic      [DATA_W-1:0]       cpu_data_o,
    output logic                         cpu_data_oe,
    // Transfer acknowledge line and bus error
    input  wire logic                    dtack_n_i,
    output logic                         dtack_n_o,
    output logic                         dtack_n_oe,
    output logic                         berr_n,
    // Byte write strobes
    output logic                         wr_hi_n,
    output logic                         wr_lo_n,
    // Triggers
    input  wire logic [TRIG_LINES-1:0]   ttl_trig,
    input  wire logic                    front_trig,
    output logic                         meas_trigger,
    // Interrupts
    input  wire logic [2:0]              analog_irq,
    input  wire logic [2:0]              irq_route_jumpers,
    input  wire logic                    user_irq_level_high,
    input  wire logic                    user_irq_level_mid,
    input  wire logic                    user_irq_level_low,
    input  wire logic [3:0]              sys_irq,
    output logic      [2:0]              ipl_n,
    // Backplane and shared bus
    input  wire logic                    bp_as_n,
    input  wire logic [ADDR_LO_W-1:0]    bp_addr_i,
    input  wire logic [ADDR_LO_W-1:0]    sh_addr_i,
    output logic      [ADDR_LO_W-1:0]    sh_addr_o,
    output logic      [ADDR_LO_W-1:0]    bp_addr_o,
    output logic      [DATA_W-1:0]       bp_addr_hi,
    output logic                         xcvr_dir,
    output logic                         xcvr_en_n,
    // Access indicators
    input  wire logic                    a16_access,
    input  wire logic                    a24_access,
    output logic                         led_a16,
    output logic                         led_a24,
    // Power
    input  wire logic                    power_good,
    input  wire logic                    ram1_req,
    output logic                         ram1_cs_n
);
    localparam int SYNC_W = 86;

    // Every pin input is resynchronised from its idle level, so no false edge follows reset
    localparam logic [SYNC_W-1:0] SYNC_IDLE = {9'h1e1, 26'h000_0000, 1'h1, 50'h0_0000_0000_0000};
    logic [SYNC_W-1:0]     sync1_ff;
    logic [SYNC_W-1:0]     sync2_ff;
    logic                  as_n_s;
    logic                  rw_s;
    logic                  uds_n_s;
    logic                  lds_n_s;
    logic                  io_s;
    logic                  mem_s;
    logic                  trig_sel_s;
    logic                  a32_sel_s;
    logic                  dtack_n_s;
    logic [WAIT_W-1:0]     wait_j_s;
    logic [TRIG_LINES-1:0] ttl_s;
    logic                  front_s;
    logic                  bp_clk_s;
    logic [2:0]            analog_s;
    logic [2:0]            route_s;
    logic [2:0]            user_s;
    logic [3:0]            sys_s;
    logic                  bp_as_n_s;
    logic [ADDR_LO_W-1:0]  bp_addr_s;
    logic [ADDR_LO_W-1:0]  sh_addr_s;
    logic [1:0]            acc_s;
    logic                  pwr_s;
    logic                  ram1_s;
    logic [DATA_W-1:0]     data_s;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sync1_ff <= SYNC_IDLE;
            sync2_ff <= SYNC_IDLE;
        end else begin
            sync1_ff <= {cpu_as_n, cpu_rw, cpu_uds_n, cpu_lds_n, io_sel, mem_sel, trigger_port_select,
                         a32_hi_sel, dtack_n_i, wait_count_jumper, ttl_trig, front_trig, bp_clk_16m,
                         analog_irq, irq_route_jumpers, user_irq_level_high, user_irq_level_mid,
                         user_irq_level_low, sys_irq, bp_as_n, bp_addr_i, sh_addr_i, a24_access,
                         a16_access, power_good, ram1_req, cpu_data_i};
            sync2_ff <= sync1_ff;
        end
    end

    assign {as_n_s, rw_s, uds_n_s, lds_n_s, io_s, mem_s, trig_sel_s, a32_sel_s, dtack_n_s, wait_j_s,
            ttl_s, front_s, bp_clk_s, analog_s, route_s, user_s, sys_s, bp_as_n_s, bp_addr_s,
            sh_addr_s, acc_s, pwr_s, ram1_s, data_s} = sync2_ff;

    // Internal state
    bca_cyc_e              state_ff;
    bca_cyc_e              nxt_state;
    logic                  io_ff;
    logic                  nxt_io;
    logic                  a32_ff;
    logic                  nxt_a32;
    logic                  bp_prev_ff;
    logic                  cpu_clk_ff;
    logic                  nxt_cpu_clk;
    logic                  bp_rise;
    logic                  as_act;
    logic                  bp_as_act;
    logic                  bp_as_prev_ff;
    logic                  trig_any_prev_ff;
    logic                  trig_any;
    logic [IRQ_LEVELS-1:0] irq_req;
    logic                  io_wr;
    logic                  trig_rd;
    bca_cyc_if             cyc ();

    assign as_act    = !as_n_s;
    assign bp_as_act = !bp_as_n_s;

    assign bp_rise     = bp_clk_s && !bp_prev_ff;
    assign nxt_cpu_clk = bp_rise ? !cpu_clk_ff : cpu_clk_ff;

    // Cycle controller
    always_comb begin
        nxt_state = state_ff;
        nxt_io    = io_ff;
        nxt_a32   = a32_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (as_act) begin
                    nxt_io    = (io_s || trig_sel_s || a32_sel_s) && !mem_s;
                    nxt_a32   = a32_sel_s && !mem_s;
                    nxt_state = mem_s ? ST_ACK : ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!as_act) begin
                    nxt_state = ST_IDLE;
                end else if (cyc.timeout) begin
                    nxt_state = ST_BERR;
                end else if (io_ff && cyc.wait_done) begin
                    nxt_state = ST_ACK;
                end
            end
            ST_ACK, ST_BERR: begin
                if (!as_act) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Timer hookup; another responder's acknowledge also stops the watchdog
    assign cyc.start       = (state_ff == ST_IDLE) && as_act;
    assign cyc.active      = (state_ff == ST_WAIT);
    assign cyc.cpu_edge    = bp_rise && !cpu_clk_ff;
    assign cyc.ack_seen    = !dtack_n_s;
    assign cyc.wait_target = wait_j_s;

    bca_cycle_timer u_timer (
        .sys_clk (sys_clk),
        .reset   (reset),
        .cyc     (cyc)
    );

    always_comb begin
        irq_req                    = '0;
        irq_req[LVL_SYS_LOW-1]     = sys_s[0];
        irq_req[LVL_USER_LOW-1]    = user_s[0] || (analog_s[0] && route_s[0]);
        irq_req[LVL_USER_MID-1]    = user_s[1] || (analog_s[1] && route_s[1]);
        irq_req[LVL_USER_HIGH-1]   = user_s[2] || (analog_s[2] && route_s[2]);
        irq_req[LVL_SYS_FIRST-1]   = sys_s[1];
        irq_req[LVL_SYS_FIRST]     = sys_s[2];
        irq_req[LVL_SYS_FIRST+1]   = sys_s[3];
    end

    bca_irq_encoder u_irq (
        .sys_clk (sys_clk),
        .reset   (reset),
        .req     (irq_req),
        .ipl_n   (ipl_n)
    );

    assign io_wr    = io_ff && (state_ff == ST_WAIT || state_ff == ST_ACK) && as_act && !rw_s;
    assign trig_rd  = as_act && rw_s && trig_sel_s && !mem_s;
    assign trig_any = (|ttl_s) || front_s;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_ff         <= ST_IDLE;
            io_ff            <= 1'b0;
            a32_ff           <= 1'b0;
            bp_prev_ff       <= 1'b0;
            cpu_clk_ff       <= 1'b0;
            bp_as_prev_ff    <= 1'b0;
            trig_any_prev_ff <= 1'b0;
            dtack_n_oe       <= 1'b0;
            berr_n           <= 1'b1;
            wr_hi_n          <= 1'b1;
            wr_lo_n          <= 1'b1;
            cpu_data_o       <= '0;
            cpu_data_oe      <= 1'b0;
            meas_trigger     <= 1'b0;
            sh_addr_o        <= '0;
            bp_addr_o        <= '0;
            bp_addr_hi       <= '0;
            xcvr_dir         <= 1'b0;
            xcvr_en_n        <= 1'b1;
            ram1_cs_n        <= 1'b1;
        end else begin
            state_ff         <= nxt_state;
            io_ff            <= nxt_io;
            a32_ff           <= nxt_a32;
            bp_prev_ff       <= bp_clk_s;
            cpu_clk_ff       <= nxt_cpu_clk;
            bp_as_prev_ff    <= bp_as_act;
            trig_any_prev_ff <= trig_any;
            dtack_n_oe       <= (nxt_state == ST_ACK);
            berr_n           <= (nxt_state != ST_BERR);
            wr_hi_n          <= !(io_wr && !uds_n_s);
            wr_lo_n          <= !(io_wr && !lds_n_s);
            cpu_data_oe      <= trig_rd;
            cpu_data_o       <= {{(DATA_W-TRIG_LINES){1'b0}}, ttl_s};
            meas_trigger     <= trig_any && !trig_any_prev_ff;
            if (bp_as_act && !bp_as_prev_ff) begin
                sh_addr_o <= bp_addr_s;
            end
            bp_addr_o        <= sh_addr_s;
            if (a32_ff && !rw_s && state_ff == ST_WAIT && nxt_state == ST_ACK) begin
                bp_addr_hi <= data_s;
            end
            xcvr_dir         <= bp_as_act;
            xcvr_en_n        <= !(bp_as_act || as_act);
            ram1_cs_n        <= !(ram1_s && pwr_s);
        end
    end

    assign cpu_clk   = cpu_clk_ff;
    assign dtack_n_o = 1'b0;

    logic [LED_CHANNELS-1:0] acc_prev_ff;
    logic [LED_CHANNELS-1:0] lit;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            acc_prev_ff <= '0;
        end else begin
            acc_prev_ff <= acc_s;
        end
    end

    for (genvar g = 0; g < LED_CHANNELS; g++) begin : g_led
        logic [LED_W-1:0] cnt_ff;
        logic [LED_W-1:0] nxt_cnt;
        logic             lit_ff;

        always_comb begin
            nxt_cnt = cnt_ff;
            if (acc_s[g] && !acc_prev_ff[g]) begin
                nxt_cnt = LED_W'(LED_STRETCH_CYCLES);
            end else if (cnt_ff != '0) begin
                nxt_cnt = cnt_ff - 1'b1;
            end
        end

        always_ff @(posedge sys_clk) begin
            if (reset) begin
                cnt_ff <= '0;
                lit_ff <= 1'b0;
            end else begin
                cnt_ff <= nxt_cnt;
                lit_ff <= (nxt_cnt != '0);
            end
        end

        assign lit[g] = lit_ff;
    end

    assign led_a16 = lit[0];
    assign led_a24 = lit[1];

    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_mem_ack;
        state_ff == ST_IDLE && as_act && mem_s |=> dtack_n_oe;
    endproperty
    a_mem_ack: assert property (p_mem_ack) else $error("Memory cycle not acknowledged at once");

    property p_io_wait;
        state_ff == ST_IDLE && as_act && !mem_s |=> !dtack_n_oe [*2];
    endproperty
    a_io_wait: assert property (p_io_wait) else $error("I/O cycle acknowledged without wait");

    property p_count_held;
        state_ff == ST_WAIT && !cyc.wait_done |=> !dtack_n_oe;
    endproperty
    a_count_held: assert property (p_count_held) else $error("Acknowledge before wait count reached");

    property p_ack_release;
        !as_act |=> !dtack_n_oe && berr_n;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("Termination held after strobe negated");

    property p_clk_div;
        bp_rise |=> cpu_clk != $past(cpu_clk);
    endproperty
    a_clk_div: assert property (p_clk_div) else $error("Processor clock missed a toggle");

    property p_trig_read;
        trig_rd |=> cpu_data_oe && cpu_data_o[TRIG_LINES-1:0] == $past(ttl_s);
    endproperty
    a_trig_read: assert property (p_trig_read) else $error("Trigger port returned wrong value");

    property p_meas_trig;
        $rose(trig_any) |=> meas_trigger ##1 !meas_trigger;
    endproperty
    a_meas_trig: assert property (p_meas_trig) else $error("Measurement trigger pulse wrong");

    property p_strobe;
        !wr_hi_n || !wr_lo_n |-> $past(io_wr) && !$past(rw_s);
    endproperty
    a_strobe: assert property (p_strobe) else $error("Write strobe outside I/O write");

    property p_pwr_loss;
        !pwr_s |=> ram1_cs_n;
    endproperty
    a_pwr_loss: assert property (p_pwr_loss) else $error("Battery bank selected without power");
endmodule

// File: bca_bus_cycle_ack_control_tb_top.sv
// Self-checking bench of the bus-cycle acknowledge controller
`timescale 1ns/1ps
module bca_bus_cycle_ack_control_tb_top import bca_pkg::*; ;
    localparam int LEDC = 20;
    logic                  sys_clk, reset, bp_clk_16m, front_trig, bp_as_n, a16_access, a24_access;
    logic                  power_good, ram1_req, cpu_clk, dtack_n_o, dtack_n_oe, berr_n, wr_hi_n, wr_lo_n;
    logic                  meas_trigger, xcvr_dir, xcvr_en_n, led_a16, led_a24, ram1_cs_n, cpu_data_oe;
    logic                  cpu_as_n, cpu_rw, cpu_uds_n, cpu_lds_n, dtack_n_i;
    logic [3:0]            sel, sys_irq;
    logic [2:0]            wait_count_jumper, analog_irq, irq_route_jumpers, usr, ipl_n;
    logic [6:0]            lv;
    logic [TRIG_LINES-1:0] ttl_trig;
    logic [DATA_W-1:0]     cpu_data_i, cpu_data_o, bp_addr_hi, dd;
    logic [ADDR_LO_W-1:0]  bp_addr_i, sh_addr_i, sh_addr_o, bp_addr_o;
    logic [2:0]            jv [3] = '{3'h1, WAIT_FITTED, 3'h7};
    int                    n_errors, samples_checked, n, nc, lo, hi, e;
    int                    exp_q[$];

    // pulled-up line, low only while driven
    assign dtack_n_i = dtack_n_oe ? dtack_n_o : 1'b1;

    bca_bus_cycle_ack_control #(.LED_STRETCH_CYCLES(LEDC)) uut (
        .sys_clk, .reset, .bp_clk_16m, .cpu_clk, .cpu_as_n, .cpu_rw, .cpu_uds_n, .cpu_lds_n,
        .io_sel(sel[0]), .mem_sel(sel[1]), .trigger_port_select(sel[2]), .a32_hi_sel(sel[3]),
        .wait_count_jumper, .cpu_data_i, .cpu_data_o, .cpu_data_oe, .dtack_n_i, .dtack_n_o,
        .dtack_n_oe, .berr_n, .wr_hi_n, .wr_lo_n, .ttl_trig, .front_trig, .meas_trigger,
        .analog_irq, .irq_route_jumpers, .user_irq_level_high(usr[2]), .user_irq_level_mid(usr[1]),
        .user_irq_level_low(usr[0]), .sys_irq, .ipl_n, .bp_as_n, .bp_addr_i, .sh_addr_i, .sh_addr_o,
        .bp_addr_o, .bp_addr_hi, .xcvr_dir, .xcvr_en_n, .a16_access, .a24_access, .led_a16, .led_a24,
        .power_good, .ram1_req, .ram1_cs_n);

    bca_cpu_model cpu (.sys_clk, .dtack_n_i, .berr_n, .cpu_as_n, .cpu_rw, .cpu_uds_n, .cpu_lds_n,
        .sel, .cpu_data_i);

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        bp_clk_16m = 1'b0;
        forever #31.25 bp_clk_16m = ~bp_clk_16m;
    end
    always @(posedge sys_clk) if (meas_trigger === 1'b1) n++;
    always @(posedge cpu_clk) nc++;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Notes per cycle: latency window, byte strobes, read word or -1
    task automatic cyc_do(input logic [3:0] s, input logic rw, input int l, input int h, input int d,
                          input logic [DATA_W-1:0] w);
        logic [1:0] ds;
        ds = 2'($urandom % 3);
        exp_q.push_back(l);
        exp_q.push_back(h);
        exp_q.push_back((s[0] && !rw) ? int'(ds) : 3);
        exp_q.push_back(d);
        cpu.run(s, rw, ds, w);
    endtask

    always @(negedge cpu_as_n) begin : mon
        int k, l, h, st, d;
        k = 0;
        do begin
            @(posedge sys_clk);
            #0.5;
            k++;
        end while (dtack_n_oe !== 1'b1 && berr_n !== 1'b0 && k < 4000);
        l = exp_q.pop_front();
        h = exp_q.pop_front();
        st = exp_q.pop_front();
        d = exp_q.pop_front();
        chk(32'(k >= l && k <= h), 32'h1);
        chk({wr_hi_n, wr_lo_n}, 32'(st));
        chk({dtack_n_i, berr_n}, (l < BERR_CYCLES) ? 32'h1 : 32'h2);
        if (d >= 0) chk({cpu_data_oe, cpu_data_o}, 32'(d));
        @(posedge cpu_as_n);
        tick(3);
        chk({dtack_n_oe, berr_n}, 32'h1);
    end

    initial begin
        #200000;
        n_errors++;
        complete_run();
    end

    initial begin
        void'($urandom(32'hf8fa));
        {reset, bp_as_n, irq_route_jumpers} = 5'h1f;
        {front_trig, a16_access, a24_access, power_good, ram1_req, usr} = 8'h00;
        {ttl_trig, analog_irq, sys_irq, bp_addr_i, sh_addr_i} = '0;
        wait_count_jumper = WAIT_FITTED;
        tick(3);
        reset = 1'b0;
        tick(2);
        foreach (jv[i]) begin
            wait_count_jumper = jv[i];
            lo = jv[i] ? (jv[i] - 1) * 25 + 3 : 3;
            hi = jv[i] * 25 + 8;
            ttl_trig = 8'($urandom);
            dd = 16'($urandom);
            cyc_do(4'b0001, 1'b0, lo, hi, -1, dd);
            cyc_do(4'b0101, 1'b1, lo, hi, {1'b1, 8'h00, ttl_trig}, dd);
            cyc_do(4'b1001, 1'b0, lo, hi, -1, dd);
            chk(bp_addr_hi, dd);
            cyc_do(4'b0010, 1'b1, 3, 3, -1, dd);
        end
        cyc_do(4'b0000, 1'b1, 3200, 3210, -1, dd);
        repeat (20) begin
            {analog_irq, irq_route_jumpers, usr, sys_irq} = 13'($urandom);
            tick(5);
            lv = {sys_irq[3:1], usr | (analog_irq & irq_route_jumpers), sys_irq[0]};
            e = 7;
            for (int i = 0; i < 7; i++) if (lv[i]) e = 6 - i;
            chk(ipl_n, 32'(e));
        end
        ttl_trig = 8'h00;
        tick(8);
        n = 0;
        front_trig = 1'b1;
        tick(10);
        chk(n, 1);
        n = 0;
        ttl_trig = 8'h08;
        tick(10);
        chk(n, 0);
        {front_trig, ttl_trig} = 9'h000;
        tick(8);
        n = 0;
        ttl_trig = 8'h80;
        tick(10);
        chk(n, 1);
        for (int i = 0; i < 4; i++) begin
            {power_good, ram1_req} = 2'(i);
            tick(5);
            chk(ram1_cs_n, 32'(i != 3));
        end
        bp_addr_i = 15'($urandom);
        sh_addr_i = 15'($urandom);
        dd = 16'(bp_addr_i);
        bp_as_n = 1'b0;
        tick(5);
        chk({xcvr_dir, xcvr_en_n, bp_addr_o}, {2'b10, sh_addr_i});
        bp_addr_i = ~bp_addr_i;
        tick(3);
        chk(sh_addr_o, dd);
        bp_as_n = 1'b1;
        tick(5);
        chk(xcvr_en_n, 1);
        {a16_access, a24_access} = 2'b11;
        tick(1);
        {a16_access, a24_access} = 2'b00;
        tick(6);
        chk({led_a16, led_a24}, 2'b11);
        tick(LEDC + 4);
        chk({led_a16, led_a24}, 2'b00);
        nc = 0;
        tick(250);
        chk(32'(nc >= 9 && nc <= 11), 32'h1);
        complete_run();
    end
endmodule

// File: bca_cpu_model.sv
// Processor-side bus master model running one access at a time
`timescale 1ns/1ps
module bca_cpu_model import bca_pkg::*; (
    // Clock and line status
    input  wire logic              sys_clk,
    input  wire logic              dtack_n_i,
    input  wire logic              berr_n,
    // Cycle request, sel is {a32, trigger port, mem, io}
    output logic                   cpu_as_n,
    output logic                   cpu_rw,
    output logic                   cpu_uds_n,
    output logic                   cpu_lds_n,
    output logic [3:0]             sel,
    output logic [DATA_W-1:0]      cpu_data_i
);
    initial begin
        {cpu_as_n, cpu_rw, cpu_uds_n, cpu_lds_n, sel, cpu_data_i} = {4'hf, 4'h0, 16'h0000};
    end

    task automatic run(input logic [3:0] s, input logic rw, input logic [1:0] ds, input logic [DATA_W-1:0] d);
        int k;
        @(posedge sys_clk);
        #1;
        {sel, cpu_rw, cpu_uds_n, cpu_lds_n, cpu_data_i} = {s, rw, ds, d};
        cpu_as_n = 1'b0;
        k = 0;
        // Everything stays put until an answer is sampled
        do begin
            @(posedge sys_clk);
            #0.5;
            k++;
        end while (dtack_n_i !== 1'b0 && berr_n !== 1'b0 && k < 4000);
        // Hold through the edge at which the answer is sampled
        @(posedge sys_clk);
        #1;
        {cpu_as_n, cpu_uds_n, cpu_lds_n, sel, cpu_data_i} = {3'h7, 4'h0, ~d};
        repeat (6) @(posedge sys_clk);
    endtask
endmodule

// File: bca_cyc_if.sv
// Cycle timing signals between the cycle controller and its timer
`timescale 1ns/1ps
interface bca_cyc_if import bca_pkg::*; ();
    logic              start;
    logic              active;
    logic              cpu_edge;
    logic              ack_seen;
    logic [WAIT_W-1:0] wait_target;
    logic              wait_done;
    logic              timeout;

    modport ctrl  (output start, active, cpu_edge, ack_seen, wait_target, input wait_done, timeout);
    modport timer (input start, active, cpu_edge, ack_seen, wait_target, output wait_done, timeout);
endinterface

// File: bca_cycle_timer.sv
// Wait-state counter and bus error timer for one processor cycle
`timescale 1ns/1ps
module bca_cycle_timer import bca_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Cycle timing
    bca_cyc_if.timer cyc
);
    logic [WAIT_W-1:0] wait_ff;
    logic [WAIT_W-1:0] nxt_wait;
    logic [BERR_W-1:0] tmo_ff;
    logic [BERR_W-1:0] nxt_tmo;

    always_comb begin
        nxt_wait = wait_ff;
        nxt_tmo  = tmo_ff;
        if (cyc.start) begin
            nxt_wait = '0;
            nxt_tmo  = '0;
        end else if (cyc.active) begin
            if (cyc.cpu_edge && !cyc.wait_done) begin
                nxt_wait = wait_ff + 1'b1;
            end
            if (!cyc.ack_seen && !cyc.timeout) begin
                nxt_tmo = tmo_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wait_ff <= '0;
            tmo_ff  <= '0;
        end else begin
            wait_ff <= nxt_wait;
            tmo_ff  <= nxt_tmo;
        end
    end

    assign cyc.wait_done = (wait_ff >= cyc.wait_target);
    assign cyc.timeout   = (tmo_ff == BERR_W'(BERR_CYCLES - 1));

    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_tmo_fire;
        cyc.active && !cyc.start && !cyc.ack_seen && tmo_ff == BERR_W'(BERR_CYCLES - 2) |=> cyc.timeout;
    endproperty
    a_tmo_fire: assert property (p_tmo_fire) else $error("Bus error timer missed its limit");
endmodule

// File: bca_irq_encoder.sv
// Priority encoder of seven autovectored interrupt levels
`timescale 1ns/1ps
module bca_irq_encoder import bca_pkg::*; (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    // Requests, bit 0 is level 1
    input  wire logic [IRQ_LEVELS-1:0] req,
    // Encoded level, active low
    output logic      [2:0]            ipl_n
);
    logic [2:0] lvl;
    logic [2:0] nxt_ipl_n;

    always_comb begin
        lvl = '0;
        for (int i = 0; i < IRQ_LEVELS; i++) begin
            if (req[i]) begin
                lvl = 3'(i + 1);
            end
        end
        nxt_ipl_n = ~lvl;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ipl_n <= '1;
        end else begin
            ipl_n <= nxt_ipl_n;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_top_wins;
        req[IRQ_LEVELS-1] |=> ipl_n == 3'h0;
    endproperty
    a_top_wins: assert property (p_top_wins) else $error("Level seven did not win");
endmodule

// File: bca_pkg.sv
// Shared constants and types of the bus-cycle acknowledge controller
package bca_pkg;
    localparam int SYS_CLK_MHZ     = 200;
    localparam int BP_CLK_MHZ      = 16;
    localparam int CPU_CLK_MHZ     = BP_CLK_MHZ / 2;
    // Longest cycle before bus error, rounded down to whole cycles
    localparam int BERR_TIME_US    = 16;
    localparam int BERR_CYCLES     = BERR_TIME_US * SYS_CLK_MHZ;
    localparam int BERR_W          = 12;
    // Indicator stretch time and counter width
    localparam int LED_STRETCH_MS  = 50;
    localparam int LED_STRETCH_DEF = LED_STRETCH_MS * 1000 * SYS_CLK_MHZ;
    localparam int LED_W           = 24;
    localparam int LED_CHANNELS    = 2;
    // Wait-state jumper width and the fitted setting
    localparam int WAIT_W          = 3;
    localparam logic [WAIT_W-1:0] WAIT_FITTED = 3'h4;
    // Interrupt levels
    localparam int IRQ_LEVELS      = 7;
    localparam int LVL_SYS_LOW     = 1;
    localparam int LVL_USER_LOW    = 2;
    localparam int LVL_USER_MID    = 3;
    localparam int LVL_USER_HIGH   = 4;
    localparam int LVL_SYS_FIRST   = 5;
    localparam int TRIG_LINES      = 8;
    localparam int DATA_W          = 16;
    localparam int ADDR_LO_W       = 15;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_WAIT = 4'h2,
        ST_ACK  = 4'h4,
        ST_BERR = 4'h8
    } bca_cyc_e;
endpackage
